// ===== gpp_pkg.sv
// constants and carrier types for the general purpose pin port
// What this block does
// - ninety-three pins share identical per-pin logic
// - pins grouped in ports of sixteen
// - direction set per pin independently
// - open-drain, filter, drive strength per pin
// - routed peripheral overrides the port value
// - peripheral location select picks overridden pin
// - sixteen external lines watch pin activity
// - each line sourced from selectable pin
// - pin level forwarded to event network
package gpp_pkg;
  // sizes
  localparam int GPP_NUM_PINS = 93;
  localparam int GPP_PORT_W = 16;
  localparam int GPP_NUM_LINES = 16;
  localparam int GPP_NUM_PERIPH = 8;
  localparam int GPP_PIN_IDX_W = 7;
  localparam int GPP_ADDR_W = 10;
  localparam int GPP_DATA_W = 32;
  localparam int GPP_ROUTE_W = 8;
  // per-port registers, port n at n * stride
  localparam logic [9:0] GPP_PORT_STRIDE = 10'h020;
  localparam logic [9:0] GPP_OFF_DIR = 10'h000;
  localparam logic [9:0] GPP_OFF_DOUT = 10'h004;
  localparam logic [9:0] GPP_OFF_DIN = 10'h008;
  localparam logic [9:0] GPP_OFF_ODEN = 10'h00C;
  localparam logic [9:0] GPP_OFF_FILT = 10'h010;
  localparam logic [9:0] GPP_OFF_DRIVE = 10'h014;
  // global registers
  localparam logic [9:0] GPP_WORD_BYTES = 10'h004;
  localparam logic [9:0] GPP_LINE_SEL_BASE = 10'h100;
  localparam logic [9:0] GPP_LINE_RISE = 10'h180;
  localparam logic [9:0] GPP_LINE_FALL = 10'h184;
  localparam logic [9:0] GPP_LINE_FLAG = 10'h188;
  localparam logic [9:0] GPP_ROUTE_BASE = 10'h1C0;

  // one register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpp_bus_req_t;

  // peripheral location select
  typedef struct packed {
    logic en;
    logic [6:0] pin;
  } gpp_route_t;
endpackage

// ===== gpp_pin_sync.sv
// per-pin input synchroniser and glitch filter
`timescale 1ns/10ps
module gpp_pin_sync
  import gpp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // pin side
  input wire logic pin_in,
  input wire logic filt_en,
  // filtered synchronous level
  output logic level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic lvl;
  } gpp_sync_t;

  gpp_sync_t st_q;
  gpp_sync_t st_d;

  // two flops, then optional two-sample agreement filter
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.prev = st_q.s2;
    if (!filt_en || (st_q.s2 == st_q.prev)) begin
      st_d.lvl = st_q.s2;
    end
  end

  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level = st_q.lvl;

  // checks
  property p_sync_depth;
    @(posedge clk) disable iff (!reset_n)
    ##2 st_q.s2 == $past(pin_in, 2);
  endproperty
  a_sync_depth: assert property (p_sync_depth)
    else $error("synchroniser depth is not two");

  property p_filter_holds;
    @(posedge clk) disable iff (!reset_n)
    (filt_en && st_q.s2 != st_q.prev) |=> $stable(st_q.lvl);
  endproperty
  a_filter_holds: assert property (p_filter_holds)
    else $error("filter passed a single-sample glitch");
endmodule

// ===== gpp_pin_port.sv
// general purpose pin port: pin control, routing, lines, events
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module gpp_pin_port
  import gpp_pkg::*;
#(
  parameter int NUM_PINS = GPP_NUM_PINS,
  parameter int NUM_LINES = GPP_NUM_LINES,
  parameter int NUM_PERIPH = GPP_NUM_PERIPH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register bus
  input wire gpp_bus_req_t bus_req,
  output logic [GPP_DATA_W-1:0] rdata,
  // device pins
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe,
  output logic [NUM_PINS-1:0] pin_drive_hi,
  // peripheral functions
  input wire logic [NUM_PERIPH-1:0] periph_out,
  input wire logic [NUM_PERIPH-1:0] periph_oe,
  output logic [NUM_PERIPH-1:0] periph_in,
  // external lines and event_routing_network
  output logic [NUM_LINES-1:0] line_flag,
  output logic [NUM_LINES-1:0] evt_level
);
  localparam int NUM_PORTS = (NUM_PINS + GPP_PORT_W - 1) / GPP_PORT_W;
  localparam int PW = NUM_PORTS * GPP_PORT_W;
  localparam int IW = GPP_PIN_IDX_W;
  localparam logic [PW-1:0] PIN_MASK = {PW{1'b1}} >> (PW - NUM_PINS);

  // parameter sanity
  if (NUM_PINS < 1 || NUM_PINS > (1 << GPP_PIN_IDX_W)
      || NUM_LINES < 1 || NUM_LINES > GPP_PORT_W
      || NUM_PERIPH < 1 || NUM_PERIPH > GPP_PORT_W) begin : g_bad_param
    $error("gpp_pin_port: unsupported parameter value");
  end

  typedef struct packed {
    logic [PW-1:0] dir;
    logic [PW-1:0] dout;
    logic [PW-1:0] oden;
    logic [PW-1:0] filt;
    logic [PW-1:0] drv;
    logic [NUM_LINES-1:0][IW-1:0] sel;
    logic [NUM_LINES-1:0] rise;
    logic [NUM_LINES-1:0] fall;
    logic [NUM_LINES-1:0] flag;
    logic [NUM_LINES-1:0] evt;
    gpp_route_t [NUM_PERIPH-1:0] route;
    logic [NUM_PINS-1:0] pout;
    logic [NUM_PINS-1:0] poe;
    logic [NUM_PERIPH-1:0] pin_to_periph;
    logic [GPP_DATA_W-1:0] rdata;
  } gpp_state_t;

  gpp_state_t st_q;
  gpp_state_t st_d;
  logic [PW-1:0] lvl_w;
  // one identical synchroniser and filter per pin
  for (genvar i = 0; i < PW; i++) begin : g_pin
    if (i < NUM_PINS) begin : g_real
      gpp_pin_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(pin_in[i]),
        .filt_en(st_q.filt[i]),
        .level(lvl_w[i])
      );
    end else begin : g_pad
      assign lvl_w[i] = 1'b0;
    end
  end
  // next state: bus access, lines, routing, pin drive
  always_comb begin
    logic [GPP_ADDR_W-1:0] base;
    logic [NUM_LINES-1:0] line;
    logic [NUM_LINES-1:0] hit;
    logic [NUM_LINES-1:0] clr;
    logic val;
    logic en;
    base = '0;
    line = '0;
    hit = '0;
    clr = '0;
    val = 1'b0;
    en = 1'b0;
    st_d = st_q;
    st_d.rdata = '0;
    // per-port control words, sixteen pins per word
    for (int p = 0; p < NUM_PORTS; p++) begin
      base = GPP_ADDR_W'(p) * GPP_PORT_STRIDE;
      if (bus_req.wr) begin
        if (bus_req.addr == base + GPP_OFF_DIR) begin
          st_d.dir[p*GPP_PORT_W +: GPP_PORT_W] =
            bus_req.wdata[GPP_PORT_W-1:0];
        end
        if (bus_req.addr == base + GPP_OFF_DOUT) begin
          st_d.dout[p*GPP_PORT_W +: GPP_PORT_W] =
            bus_req.wdata[GPP_PORT_W-1:0];
        end
        if (bus_req.addr == base + GPP_OFF_ODEN) begin
          st_d.oden[p*GPP_PORT_W +: GPP_PORT_W] =
            bus_req.wdata[GPP_PORT_W-1:0];
        end
        if (bus_req.addr == base + GPP_OFF_FILT) begin
          st_d.filt[p*GPP_PORT_W +: GPP_PORT_W] =
            bus_req.wdata[GPP_PORT_W-1:0];
        end
        if (bus_req.addr == base + GPP_OFF_DRIVE) begin
          st_d.drv[p*GPP_PORT_W +: GPP_PORT_W] =
            bus_req.wdata[GPP_PORT_W-1:0];
        end
      end
      if (bus_req.rd) begin
        if (bus_req.addr == base + GPP_OFF_DIR) begin
          st_d.rdata[GPP_PORT_W-1:0] = st_q.dir[p*GPP_PORT_W +: GPP_PORT_W];
        end
        if (bus_req.addr == base + GPP_OFF_DOUT) begin
          st_d.rdata[GPP_PORT_W-1:0] = st_q.dout[p*GPP_PORT_W +: GPP_PORT_W];
        end
        if (bus_req.addr == base + GPP_OFF_DIN) begin
          st_d.rdata[GPP_PORT_W-1:0] = lvl_w[p*GPP_PORT_W +: GPP_PORT_W];
        end
        if (bus_req.addr == base + GPP_OFF_ODEN) begin
          st_d.rdata[GPP_PORT_W-1:0] = st_q.oden[p*GPP_PORT_W +: GPP_PORT_W];
        end
        if (bus_req.addr == base + GPP_OFF_FILT) begin
          st_d.rdata[GPP_PORT_W-1:0] = st_q.filt[p*GPP_PORT_W +: GPP_PORT_W];
        end
        if (bus_req.addr == base + GPP_OFF_DRIVE) begin
          st_d.rdata[GPP_PORT_W-1:0] = st_q.drv[p*GPP_PORT_W +: GPP_PORT_W];
        end
      end
    end
    // bits of absent pins stay zero
    st_d.dir = st_d.dir & PIN_MASK;
    st_d.dout = st_d.dout & PIN_MASK;
    st_d.oden = st_d.oden & PIN_MASK;
    st_d.filt = st_d.filt & PIN_MASK;
    st_d.drv = st_d.drv & PIN_MASK;
    // external lines: source select, edge enables, sticky flags
    for (int k = 0; k < NUM_LINES; k++) begin
      base = GPP_LINE_SEL_BASE + GPP_ADDR_W'(k) * GPP_WORD_BYTES;
      line[k] = lvl_w[st_q.sel[k]];
      if (bus_req.wr && bus_req.addr == base
          && bus_req.wdata < NUM_PINS) begin
        st_d.sel[k] = bus_req.wdata[IW-1:0];
      end
      if (bus_req.rd && bus_req.addr == base) begin
        st_d.rdata[IW-1:0] = st_q.sel[k];
      end
    end
    if (bus_req.wr && bus_req.addr == GPP_LINE_RISE) begin
      st_d.rise = bus_req.wdata[NUM_LINES-1:0];
    end
    if (bus_req.wr && bus_req.addr == GPP_LINE_FALL) begin
      st_d.fall = bus_req.wdata[NUM_LINES-1:0];
    end
    if (bus_req.wr && bus_req.addr == GPP_LINE_FLAG) begin
      clr = bus_req.wdata[NUM_LINES-1:0];   // write one to clear
    end
    if (bus_req.rd && bus_req.addr == GPP_LINE_RISE) begin
      st_d.rdata[NUM_LINES-1:0] = st_q.rise;
    end
    if (bus_req.rd && bus_req.addr == GPP_LINE_FALL) begin
      st_d.rdata[NUM_LINES-1:0] = st_q.fall;
    end
    if (bus_req.rd && bus_req.addr == GPP_LINE_FLAG) begin
      st_d.rdata[NUM_LINES-1:0] = st_q.flag;
    end
    // edge detect on the filtered level, set beats clear
    hit = (line & ~st_q.evt & st_q.rise) | (~line & st_q.evt & st_q.fall);
    st_d.flag = (st_q.flag & ~clr) | hit;
    st_d.evt = line;
    // peripheral location selects
    for (int j = 0; j < NUM_PERIPH; j++) begin
      base = GPP_ROUTE_BASE + GPP_ADDR_W'(j) * GPP_WORD_BYTES;
      if (bus_req.wr && bus_req.addr == base
          && bus_req.wdata[IW-1:0] < NUM_PINS) begin
        st_d.route[j] = gpp_route_t'(bus_req.wdata[GPP_ROUTE_W-1:0]);
      end
      if (bus_req.rd && bus_req.addr == base) begin
        st_d.rdata[GPP_ROUTE_W-1:0] = st_q.route[j];
      end
      st_d.pin_to_periph[j] = lvl_w[st_q.route[j].pin];
    end
    // pin drive: lowest-numbered routed peripheral wins
    for (int i = 0; i < NUM_PINS; i++) begin
      val = st_q.dout[i];
      en = st_q.dir[i];
      for (int j = NUM_PERIPH - 1; j >= 0; j--) begin
        if (st_q.route[j].en && st_q.route[j].pin == IW'(i)) begin
          val = periph_out[j];
          en = periph_oe[j];
        end
      end
      if (st_q.oden[i]) begin
        st_d.pout[i] = 1'b0;
        st_d.poe[i] = en & ~val;
      end else begin
        st_d.pout[i] = val;
        st_d.poe[i] = en;
      end
    end
  end
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // outputs straight from flops
  assign rdata = st_q.rdata;
  assign pin_out = st_q.pout;
  assign pin_oe = st_q.poe;
  assign pin_drive_hi = st_q.drv[NUM_PINS-1:0];
  assign periph_in = st_q.pin_to_periph;
  assign line_flag = st_q.flag;
  assign evt_level = st_q.evt;
  // checks
  property p_port_width;
    @(posedge clk) disable iff (!reset_n)
    (bus_req.rd && bus_req.addr == GPP_OFF_DIN)
      |=> rdata[GPP_DATA_W-1:GPP_PORT_W] == '0
          && rdata[GPP_PORT_W-1:0] == $past(lvl_w[GPP_PORT_W-1:0]);
  endproperty
  a_port_width: assert property (p_port_width)
    else $error("port read wrong");
  property p_dir_write;
    @(posedge clk) disable iff (!reset_n)
    (bus_req.wr && bus_req.addr == GPP_OFF_DIR)
      |=> st_q.dir[GPP_PORT_W-1:0] == $past(bus_req.wdata[GPP_PORT_W-1:0]);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write lost");
  property p_open_drain;
    @(posedge clk) disable iff (!reset_n)
    $past(st_q.oden[0]) |-> !pin_out[0];
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin driven high");
  property p_override;
    @(posedge clk) disable iff (!reset_n)
    ($past(st_q.route[0].en) && $past(st_q.route[0].pin) == '0
     && !$past(st_q.oden[0]))
      |-> pin_out[0] == $past(periph_out[0])
          && pin_oe[0] == $past(periph_oe[0]);
  endproperty
  a_override: assert property (p_override)
    else $error("peripheral did not override pin");
  property p_route_write;
    @(posedge clk) disable iff (!reset_n)
    (bus_req.wr && bus_req.addr == GPP_ROUTE_BASE
     && bus_req.wdata[IW-1:0] < NUM_PINS)
      |=> st_q.route[0] == $past(bus_req.wdata[GPP_ROUTE_W-1:0]);
  endproperty
  a_route_write: assert property (p_route_write)
    else $error("location select not stored");
  property p_rise_flag;
    @(posedge clk) disable iff (!reset_n)
    ($rose(st_q.evt[0]) && $past(st_q.rise[0])) |-> st_q.flag[0];
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("rising edge not flagged");
  property p_fall_flag;
    @(posedge clk) disable iff (!reset_n)
    ($fell(st_q.evt[0]) && $past(st_q.fall[0])) |-> st_q.flag[0];
  endproperty
  a_fall_flag: assert property (p_fall_flag)
    else $error("falling edge not flagged");
  property p_flag_sticky;
    @(posedge clk) disable iff (!reset_n)
    (st_q.flag[0] && !(bus_req.wr && bus_req.addr == GPP_LINE_FLAG))
      |=> st_q.flag[0];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("flag dropped without clear");
  property p_line_src;
    @(posedge clk) disable iff (!reset_n)
    $stable(st_q.sel[0]) |-> evt_level[0] == $past(lvl_w[st_q.sel[0]]);
  endproperty
  a_line_src: assert property (p_line_src)
    else $error("line not following selected pin");
  property p_evt_fwd;
    @(posedge clk) disable iff (!reset_n)
    (bus_req.wr && bus_req.addr == GPP_LINE_SEL_BASE
     && bus_req.wdata < NUM_PINS)
      |=> st_q.sel[0] == $past(bus_req.wdata[IW-1:0])
      ##1 evt_level[0] == $past(lvl_w[st_q.sel[0]]);
  endproperty
  a_evt_fwd: assert property (p_evt_fwd)
    else $error("event level not forwarded");
endmodule

// ===== gpp_pin_model.sv
// far-side model of the device pins with loop-back of driven pins
`timescale 1ns/10ps
module gpp_pin_model
  import gpp_pkg::*;
(
  // port drive
  input wire logic [GPP_NUM_PINS-1:0] pin_out,
  input wire logic [GPP_NUM_PINS-1:0] pin_oe,
  // outside world level where the port lets go
  input wire logic [GPP_NUM_PINS-1:0] ext_val,
  // level seen back at the pins
  output logic [GPP_NUM_PINS-1:0] pin_in
);
  // a driven pin reads its own value, a released one the outside level
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val);
  end
endmodule

// ===== gpp_pin_port_tb.sv
// self-checking testbench for the general purpose pin port
`timescale 1ns/10ps
module gpp_pin_port_tb
  import gpp_pkg::*;
;
  // clock, reset, bus
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  gpp_bus_req_t req = '0;
  logic [31:0] rdata;
  // pins and peripherals
  logic [GPP_NUM_PINS-1:0] pin_in, pin_out, pin_oe, drv;
  logic [GPP_NUM_PINS-1:0] ext = '0;
  logic [7:0] p_out = '0;
  logic [7:0] p_oe = '0;
  logic [7:0] p_in;
  logic [15:0] flag, evt;
  // padded views and expectations
  logic [95:0] oe96, out96, drv96, ext96, din96;
  logic [95:0] dir96 = '0;
  logic [95:0] dout96 = '0;
  logic [31:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [15:0] d, o, v;
  int p;
  int error_cnt = 0;
  int n_tests = 0;

  assign oe96 = 96'(pin_oe);
  assign out96 = 96'(pin_out);
  assign drv96 = 96'(drv);
  assign ext96 = 96'(ext);
  assign din96 = (dir96 & dout96) | (~dir96 & ext96);

  always #2.5 clk = ~clk;

  gpp_pin_port u_gpp_pin_port (
    .clk(clk), .reset_n(reset_n), .bus_req(req), .rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_drive_hi(drv), .periph_out(p_out), .periph_oe(p_oe),
    .periph_in(p_in), .line_flag(flag), .evt_level(evt)
  );

  gpp_pin_model u_gpp_pin_model (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext), .pin_in(pin_in)
  );

  // verdict and end of run
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus write, one cycle strobe
  task automatic wr(input logic [9:0] a, input logic [31:0] dat);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= dat;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // bus read, expectation noted for the monitor
  task automatic rd(input logic [9:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(exp);
    @(posedge clk);
    req.rd <= 1'b0;
  endtask

  // bounded wait for a line flag
  task automatic wt(input int k);
    int i;
    for (i = 0; i < 10 && flag[k] !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk(32'(flag[k]), 32'h1);
    if (flag[k] !== 1'b1) begin
      give_verdict();
    end
  endtask

  function automatic logic [15:0] msk(input int n);
    return (n == 5) ? 16'h1FFF : 16'hFFFF;
  endfunction

  function automatic logic [9:0] ad(input int n, input logic [9:0] off);
    return 10'(n * 32) + off;
  endfunction

  // read data stands one cycle after the strobe
  always @(posedge clk) begin
    rd_d <= req.rd;
    if (rd_d) begin
      chk(rdata, exp_q.pop_front());
    end
  end

  // main sequence
  initial begin
    void'($urandom(40953));
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(pin_oe[31:0], 32'h0);
    chk(32'(flag), 32'h0);
    // per-port direction, value and drive
    for (p = 0; p < 6; p++) begin
      d = 16'($urandom);
      o = 16'($urandom);
      v = 16'($urandom);
      dir96[p*16+:16] = d & msk(p);
      dout96[p*16+:16] = o & msk(p);
      wr(ad(p, GPP_OFF_DIR), 32'(d));
      wr(ad(p, GPP_OFF_DOUT), 32'(o));
      wr(ad(p, GPP_OFF_DRIVE), 32'(v));
      rd(ad(p, GPP_OFF_DIR), 32'(d & msk(p)));
      @(posedge clk);
      #1;
      chk(32'(oe96[p*16+:16]), 32'(d & msk(p)));
      chk(32'(out96[p*16+:16]), 32'(o & msk(p)));
      chk(32'(drv96[p*16+:16]), 32'(v & msk(p)));
    end
    // synchronised input levels of all pins
    @(posedge clk);
    ext <= GPP_NUM_PINS'({$urandom, $urandom, $urandom});
    repeat (5) @(posedge clk);
    for (p = 0; p < 6; p++) begin
      rd(ad(p, GPP_OFF_DIN), 32'(din96[p*16+:16] & msk(p)));
    end
    rd(10'h0FC, 32'h0);
    // open drain on port 0
    wr(ad(0, GPP_OFF_ODEN), 32'hFFFF);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(pin_out[15:0]), 32'h0);
    chk(32'(pin_oe[15:0]), 32'(dir96[15:0] & ~dout96[15:0]));
    // peripheral 1 takes pin 35, then moves to pin 36
    p_out <= 8'h02;
    p_oe <= 8'h02;
    wr(GPP_ROUTE_BASE + 10'h004, 32'hA3);
    repeat (5) @(posedge clk);
    #1;
    chk(32'(pin_out[35]), 32'h1);
    chk(32'(pin_oe[35]), 32'h1);
    chk(32'(p_in[1]), 32'h1);
    wr(GPP_ROUTE_BASE + 10'h004, 32'hE4);
    rd(GPP_ROUTE_BASE + 10'h004, 32'hA3);
    wr(GPP_ROUTE_BASE + 10'h004, 32'hA4);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(pin_oe[35]), 32'(dir96[35]));
    chk(32'(pin_oe[36]), 32'h1);
    // line 3 watches pin 50
    dir96[63:48] = '0;
    wr(ad(3, GPP_OFF_DIR), 32'h0);
    ext[50] <= 1'b0;
    wr(GPP_LINE_SEL_BASE + 10'h00C, 32'd50);
    wr(GPP_LINE_RISE, 32'h8);
    wr(GPP_LINE_FLAG, 32'hFFFF);
    @(posedge clk);
    ext[50] <= 1'b1;
    wt(3);
    chk(32'(evt[3]), 32'h1);
    @(posedge clk);
    ext[50] <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(32'(flag[3]), 32'h1);
    chk(32'(evt[3]), 32'h0);
    rd(GPP_LINE_FLAG, 32'h8);
    wr(GPP_LINE_FLAG, 32'h8);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(flag[3]), 32'h0);
    wr(GPP_LINE_RISE, 32'h0);
    wr(GPP_LINE_FALL, 32'h8);
    ext[50] <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk(32'(flag[3]), 32'h0);
    @(posedge clk);
    ext[50] <= 1'b0;
    wt(3);
    // peripheral 0 outranks 1 on pin 36, then moves to pin 0
    p_oe <= 8'h03;
    wr(ad(0, GPP_OFF_ODEN), 32'h0);
    wr(GPP_ROUTE_BASE, 32'hA4);
    repeat (2) @(posedge clk);
    #1;
    chk(32'(pin_out[36]), 32'h0);
    chk(32'(pin_oe[36]), 32'h1);
    wr(GPP_ROUTE_BASE, 32'h80);
    rd(GPP_ROUTE_BASE, 32'h80);
    #1;
    chk(32'(pin_out[36]), 32'h1);
    chk(32'({pin_oe[0], pin_out[0]}), 32'h2);
    // line 0 joins line 3 on pin 50, filter on, one-cycle glitch
    wr(GPP_LINE_SEL_BASE, 32'd50);
    wr(ad(3, GPP_OFF_FILT), 32'h4);
    wr(GPP_LINE_RISE, 32'h1);
    wr(GPP_LINE_FLAG, 32'hFFFF);
    ext[50] <= 1'b1;
    @(posedge clk);
    ext[50] <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk(32'(flag), 32'h0);
    // steady level passes the filter
    ext[50] <= 1'b1;
    wt(0);
    chk(32'(evt), 32'h9);
    chk(32'(flag), 32'h1);
    wr(GPP_LINE_FALL, 32'h1);
    wr(GPP_LINE_FLAG, 32'h1);
    ext[50] <= 1'b0;
    wt(0);
    rd(GPP_LINE_SEL_BASE, 32'd50);
    rd(ad(3, GPP_OFF_FILT), 32'h4);
    rd(GPP_LINE_FALL, 32'h1);
    #1;
    chk(32'(p_in), 32'h2);
    repeat (3) @(posedge clk);
    give_verdict();
  end

  // hang guard
  initial begin
    #200us;
    error_cnt++;
    give_verdict();
  end
endmodule
